// File: core/mai_regs.svh
// Purpose: timing counts for the multiplier access interlock
// Assumes: one core clock, counts in cycles
// Notes: definitions only
`ifndef MAI_REGS_SVH
`define MAI_REGS_SVH
`define MAI_MAC_MA_CYCLES 2'h2
`define MAI_MAC_MM_CYCLES 2'h2
`define MAI_OCC_W 3
`endif

// File: core/mai_pkg.sv
// Purpose: types for the multiplier access interlock
// Assumes: instruction class decoded upstream
// Notes: one-hot stage states
package mai_pkg;
   typedef enum logic [2:0]
   {
      MAI_OP_OTHER = 3'h0,
      MAI_OP_MAC = 3'h1,
      MAI_OP_DMUL = 3'h2,
      MAI_OP_COPY = 3'h3,
      MAI_OP_STORE = 3'h4
   } mai_op_t;
   typedef enum logic [3:0]
   {
      MAI_ST_IDLE = 4'b0001,
      MAI_ST_ACC = 4'b0010,
      MAI_ST_WAIT = 4'b0100,
      MAI_ST_WB = 4'b1000
   } mai_state_t;
endpackage

// File: core/mai_interlock.sv
// Purpose: memory-access stage interlock against a busy multiply unit
// Assumes: op_valid is a one-cycle pulse as an op leaves execute_stage
// Notes: mul_acc_word occupancy tracked by a cycle counter
// How it works
// RULE1 - double_signed_multiply gets a memory_access_stage to reach the multiplier.
// RULE2 - that stage never stalls on a preceding mul_acc_word busy cycle.
// RULE3 - its memory_access_stage colliding with fetch splits the slot.
// RULE4 - system_reg_copy_out gets a multiplier-access memory_access_stage.
// RULE5 - copy-out access stretches until multiplier_busy_cycle ends, one slot.
// RULE6 - copy-out access contends with instruction fetch for the bus.
// RULE7 - system_reg_store_memory stage reads multiplier and writes memory.
// RULE8 - store waits for multiplier unless cached variant with cache on.
// RULE9 - mul_acc_word occupies two access stages then two busy cycles.
// RULE10 - copy-out result written in writeback_stage one cycle after access.
`timescale 1ns/1ns
`default_nettype none
`include "mai_regs.svh"
module mai_interlock
   import mai_pkg::*;
#(
   parameter bit CACHED_VARIANT = 1'b1
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // issue from execute_stage
   input wire logic op_valid,
   input wire mai_op_t op_kind,
   // cache state and fetch request
   input wire logic cache_on,
   input wire logic fetch_req,
   // results
   output logic mul_access_reg,
   output logic mem_write_reg,
   output logic bus_data_reg,
   output logic fetch_grant_reg,
   output logic stall_reg,
   output logic mul_busy_reg,
   output logic wb_write_reg
);
   logic [`MAI_OCC_W-1:0] occ_reg;
   mai_state_t state_reg;
   mai_op_t kind_reg;
   logic busy_now;
   logic held_next;
   logic waits;
   logic bus_user;
   logic collide;

   function automatic logic needs_wait(input mai_op_t k, input logic c);
      case (k)
         MAI_OP_COPY: needs_wait = 1'b1; // [RULE5]
         MAI_OP_STORE: needs_wait = !(CACHED_VARIANT && c); // [RULE8]
         default: needs_wait = 1'b0; // [RULE2]
      endcase
   endfunction

   // busy during the two multiplier_busy_cycle slots after two accesses
   assign busy_now = (occ_reg != 3'h0) && (occ_reg <= 3'(`MAI_MAC_MM_CYCLES));
   // window still held in the cycle an access would take next
   assign held_next = occ_reg > 3'h1; // [RULE9]
   assign waits = needs_wait(kind_reg, cache_on) && held_next; // [RULE5]
   // every tracked access stage uses the shared bus
   assign bus_user = state_reg == MAI_ST_ACC && kind_reg != MAI_OP_OTHER;
   assign collide = bus_user && fetch_req && !fetch_grant_reg; // [RULE3]

   // occupancy counter must hold the whole window
   generate
      if (int'(`MAI_MAC_MA_CYCLES) + int'(`MAI_MAC_MM_CYCLES) >=
         (1 << `MAI_OCC_W) || int'(`MAI_MAC_MM_CYCLES) < 1)
      begin : g_occ_check
         $error("occupancy counter cannot hold the window");
      end
   endgenerate

   // mul_acc_word occupancy window
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         occ_reg <= 3'h0;
      else if (op_valid && op_kind == MAI_OP_MAC)
         occ_reg <= 3'(`MAI_MAC_MA_CYCLES) +
            3'(`MAI_MAC_MM_CYCLES); // [RULE9]
      else if (occ_reg != 3'h0)
         occ_reg <= occ_reg - 3'h1;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         mul_busy_reg <= 1'b0;
      else
         mul_busy_reg <= busy_now;
   end

   // access stage sequencing
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_reg <= MAI_ST_IDLE;
         kind_reg <= MAI_OP_OTHER;
      end
      else
      begin
         case (state_reg)
            MAI_ST_IDLE:
            begin
               if (op_valid && op_kind inside {MAI_OP_DMUL, MAI_OP_COPY,
                   MAI_OP_STORE})
               begin
                  kind_reg <= op_kind; // [RULE1] [RULE4] [RULE7]
                  state_reg <= MAI_ST_WAIT;
               end
            end
            MAI_ST_WAIT:
               if (!waits)
                  state_reg <= MAI_ST_ACC; // [RULE5]
            MAI_ST_ACC:
            begin
               // fetch collision splits the slot; access holds one more
               if (collide)
                  state_reg <= MAI_ST_ACC; // [RULE3] [RULE6]
               else if (kind_reg == MAI_OP_COPY)
                  state_reg <= MAI_ST_WB; // [RULE10]
               else
                  state_reg <= MAI_ST_IDLE;
            end
            MAI_ST_WB:
               state_reg <= MAI_ST_IDLE;
            default:
               state_reg <= MAI_ST_IDLE;
         endcase
      end
   end

   // bus arbitration: fetch takes first half of a split slot
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         fetch_grant_reg <= 1'b0;
      else
         fetch_grant_reg <= collide; // [RULE3] [RULE6]
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         mul_access_reg <= 1'b0;
         mem_write_reg <= 1'b0;
         bus_data_reg <= 1'b0;
         stall_reg <= 1'b0;
         wb_write_reg <= 1'b0;
      end
      else
      begin
         mul_access_reg <= state_reg == MAI_ST_ACC &&
            !(fetch_req && !fetch_grant_reg); // [RULE1] [RULE4]
         mem_write_reg <= state_reg == MAI_ST_ACC && kind_reg == MAI_OP_STORE
            && !(fetch_req && !fetch_grant_reg); // [RULE7]
         bus_data_reg <= state_reg == MAI_ST_ACC &&
            !(fetch_req && !fetch_grant_reg);
         stall_reg <= state_reg == MAI_ST_WAIT && waits; // [RULE5] [RULE8]
         wb_write_reg <= state_reg == MAI_ST_WB; // [RULE10]
      end
   end

   AST_DMUL_NO_STALL: // [RULE2]
      assert property (@(posedge clk) disable iff (!reset_n)
         state_reg == MAI_ST_WAIT && kind_reg == MAI_OP_DMUL |=> !stall_reg)
      else $error("double multiply stalled on busy multiplier");
   AST_COPY_STALL: // [RULE5]
      assert property (@(posedge clk) disable iff (!reset_n)
         state_reg == MAI_ST_WAIT && kind_reg == MAI_OP_COPY && held_next
         |=> stall_reg)
      else $error("copy-out not stretched while multiplier busy");
   AST_WB_AFTER: // [RULE10]
      assert property (@(posedge clk) disable iff (!reset_n)
         state_reg == MAI_ST_WB |=> wb_write_reg)
      else $error("writeback missing after copy-out access");
   AST_OCC: // [RULE9]
      assert property (@(posedge clk) disable iff (!reset_n)
         op_valid && op_kind == MAI_OP_MAC ##1
         (!(op_valid && op_kind == MAI_OP_MAC)) [*3]
         |-> busy_now ##1 busy_now ##1 !busy_now)
      else $error("mul_acc_word occupancy window wrong");
   AST_OCC_ACCESS: // [RULE9]
      assert property (@(posedge clk) disable iff (!reset_n)
         op_valid && op_kind == MAI_OP_MAC |=> !busy_now ##1 !busy_now)
      else $error("mul_acc_word busy during its access stages");
   AST_STORE_CACHE: // [RULE8]
      assert property (@(posedge clk) disable iff (!reset_n)
         state_reg == MAI_ST_WAIT && kind_reg == MAI_OP_STORE && CACHED_VARIANT
         && cache_on |=> !stall_reg)
      else $error("cached store stalled");
   AST_SPLIT: // [RULE3]
      assert property (@(posedge clk) disable iff (!reset_n)
         state_reg == MAI_ST_ACC && fetch_req && !fetch_grant_reg
         |=> fetch_grant_reg && !mul_access_reg)
      else $error("fetch collision not split");
   AST_WRITE_STORE: // [RULE7]
      assert property (@(posedge clk) disable iff (!reset_n)
         mem_write_reg |-> mul_access_reg)
      else $error("store write without multiplier read");
   AST_ACCESS_ONCE: // [RULE1]
      assert property (@(posedge clk) disable iff (!reset_n)
         state_reg == MAI_ST_ACC && !(fetch_req && !fetch_grant_reg)
         |=> mul_access_reg)
      else $error("access stage missing");
   AST_COPY_AFTER_MUL: // [RULE5]
      assert property (@(posedge clk) disable iff (!reset_n)
         state_reg == MAI_ST_ACC && kind_reg == MAI_OP_COPY |-> !busy_now)
      else $error("copy-out reached multiplier while it was busy");
   AST_STORE_WAITS: // [RULE8]
      assert property (@(posedge clk) disable iff (!reset_n)
         state_reg == MAI_ST_WAIT && kind_reg == MAI_OP_STORE
         && !(CACHED_VARIANT && cache_on) && held_next |=> stall_reg)
      else $error("uncached store did not wait for multiplier");
   AST_STALL_NO_ACCESS: // [RULE5]
      assert property (@(posedge clk) disable iff (!reset_n)
         stall_reg |-> !mul_access_reg && !bus_data_reg)
      else $error("access made while stretched");
   AST_GRANT_ONE: // [RULE3]
      assert property (@(posedge clk) disable iff (!reset_n)
         fetch_grant_reg |=> !fetch_grant_reg)
      else $error("fetch held the split slot twice");
   AST_BUS_OWNER: // [RULE6]
      assert property (@(posedge clk) disable iff (!reset_n)
         fetch_grant_reg |-> !bus_data_reg)
      else $error("fetch and data access share one slot");
endmodule
`default_nettype wire

// File: verification/mai_fetch_model.sv
// Purpose: fetch side of the shared bus
// Assumes: one fetch pending at a time
// Notes: request held until granted
`timescale 1ns/1ns
`default_nettype none
module mai_fetch_model
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // control
   input wire logic want,
   input wire logic grant,
   // bus request
   output logic fetch_req
);
   always_ff @(posedge clk)
   begin
      if (!reset_n || grant)
         fetch_req <= 1'b0;
      else if (want)
         fetch_req <= 1'b1;
   end
endmodule
`default_nettype wire

// File: verification/tb.sv
// Purpose: self-checking bench for the interlock
// Assumes: dut_u cached variant, dut_v uncached variant
// Notes: rows mac,op,cache,fetch then stall,grant,write,wb
`timescale 1ns/1ns
`default_nettype none
module tb;
   import mai_pkg::*;
   logic clk, reset_n, op_valid, cache_on, want, fetch_req;
   logic acc, wr, bd, gr, st, busy, wb, stv;
   mai_op_t op_kind;
   int err_count, checks, cyc, ns, ng, nw, nb, nd, nv, tg, ta, tw;
   logic [9:0] rows [7] = '{10'h2a0, 10'h2e9, 10'h322, 10'h30a,
      10'h0b4, 10'h0f5, 10'h220};
   mai_interlock dut_u (.clk(clk), .reset_n(reset_n), .op_valid(op_valid),
      .op_kind(op_kind), .cache_on(cache_on), .fetch_req(fetch_req),
      .mul_access_reg(acc), .mem_write_reg(wr), .bus_data_reg(bd),
      .fetch_grant_reg(gr), .stall_reg(st), .mul_busy_reg(busy),
      .wb_write_reg(wb));
   mai_fetch_model fm_u (.clk(clk), .reset_n(reset_n), .want(want),
      .grant(gr), .fetch_req(fetch_req));
   mai_interlock #(.CACHED_VARIANT(1'b0)) dut_v (.clk(clk),
      .reset_n(reset_n), .op_valid(op_valid), .op_kind(op_kind),
      .cache_on(cache_on), .fetch_req(fetch_req), .mul_access_reg(),
      .mem_write_reg(), .bus_data_reg(), .fetch_grant_reg(),
      .stall_reg(stv), .mul_busy_reg(), .wb_write_reg());
   task automatic chk(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic observe();
      {ns, ng, nw, nb, nd, nv, ta, tw} = '0;
      tg = 99;
      for (int i = 1; i < 20; i++)
      begin
         @(negedge clk);
         ns += (st === 1'b1);
         ng += (gr === 1'b1);
         nw += (wr === 1'b1);
         nb += (busy === 1'b1);
         nd += (bd === 1'b1);
         nv += (stv === 1'b1);
         if (gr === 1'b1 && tg == 99)
            tg = i;
         if (acc === 1'b1)
            ta = i;
         if (wb === 1'b1)
            tw = i;
      end
      @(posedge clk);
   endtask
   task automatic run(input logic [9:0] r);
      cache_on <= r[5];
      want <= r[4];
      if (r[9])
      begin
         op_valid <= 1'b1;
         op_kind <= MAI_OP_MAC;
         @(posedge clk);
      end
      op_valid <= 1'b1;
      op_kind <= mai_op_t'(r[8:6]);
      @(posedge clk);
      op_valid <= 1'b0;
      want <= 1'b0;
      observe();
      chk(ns != 0, r[3]);
      chk(tg != 99, r[2]);
      chk(nw != 0, r[1]);
      chk(tw != 0, r[0]);
      if (r[8:6] != 3'h0)
         chk(ta != 0, 1'b1);
      else
         chk(nb == 2, 1'b1);
      if (r[2])
         chk(tg < ta, 1'b1);
      if (r[0])
         chk(tw == ta + 1, 1'b1);
      chk(ng == 1, r[2]);
      chk(nd == 1, r[8:6] != 3'h0);
      if (r[8:6] == 3'h4)
         chk(nv != 0, 1'b1);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         err_count++;
         conclude();
      end
   end
   initial
   begin
      {reset_n, op_valid, cache_on, want} = '0;
      op_kind = MAI_OP_OTHER;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk({acc, wr, bd, gr, st, busy, wb} == 7'h00, 1'b1);
      @(posedge clk);
      foreach (rows[i])
         run(rows[i]);
      // back-to-back mul_acc_word: copy-out waits for the second one
      op_valid <= 1'b1;
      op_kind <= MAI_OP_MAC;
      @(posedge clk);
      @(posedge clk);
      op_kind <= MAI_OP_COPY;
      @(posedge clk);
      op_valid <= 1'b0;
      observe();
      chk(ns == 2, 1'b1);
      chk(tw == ta + 1, 1'b1);
      // reset in mid-run while copy-out is stretched
      op_valid <= 1'b1;
      op_kind <= MAI_OP_MAC;
      @(posedge clk);
      op_kind <= MAI_OP_COPY;
      @(posedge clk);
      op_valid <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b0;
      @(negedge clk);
      chk(st, 1'b1);
      @(posedge clk);
      reset_n <= 1'b1;
      repeat (2)
      begin
         @(negedge clk);
         chk({acc, wr, bd, gr, st, busy, wb} == 7'h00, 1'b1);
      end
      @(posedge clk);
      run(rows[1]);
      conclude();
   end
endmodule
`default_nettype wire
